// ==== design/vpce_map.svh ====
// Address map, field layout and codes of the virtual port block
// Contract
// - Map nibble picks port A..P in order
// - Window access equals physical access to DIR, OUT, IN and FLAGS
// - Pin-choice bit moves clock and event outputs to pin four
// - RTC enable drives RTC clock on C6
// - Event port field: off, C, D, E
// - Event reaches pin only if output
// - Rate field picks 1x, 2x, 4x clock
// - Clock port field: off, C, D, E
// - Clock wins over event on shared pin
// - Clock reaches pin only if output
// - Channel field picks event channel 0..7
// - Input reads pin, zero when buffer off
// - Matching sense on masked pin sets flag
// - Writing one clears flag, zero keeps
// - Sense codes: both, rise, fall, low, off
`ifndef VPCE_MAP_SVH
`define VPCE_MAP_SVH

// ----------------------------------------
// Configuration registers (index, byte = 4 * index)
// ----------------------------------------
`define VPCE_CTRLA_IDX 6'h02
`define VPCE_CTRLB_IDX 6'h03
`define VPCE_CLKEV_IDX 6'h04
`define VPCE_EVCTL_IDX 6'h06
`define VPCE_IRQ_STAT_IDX 6'h08
`define VPCE_IRQ_CLR_IDX 6'h09
`define VPCE_IRQ_EN_IDX 6'h0A

// ----------------------------------------
// Windows and physical port banks
// ----------------------------------------
`define VPCE_VP_BASE 12'h040
`define VPCE_VP_END 12'h080
`define VPCE_PP_BASE 12'h100
`define VPCE_PP_END 12'h300
`define VPCE_P_DIR 3'h0
`define VPCE_P_OUT 3'h1
`define VPCE_P_IN 3'h2
`define VPCE_P_FLAGS 3'h3
`define VPCE_P_MASK0 3'h4
`define VPCE_P_MASK1 3'h5
`define VPCE_P_SENSE 3'h6

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define VPCE_CLKEV_RST 8'h00
`define VPCE_PIN_ALT 3'h4
`define VPCE_PIN_DEF 3'h7
`define VPCE_RTC_PIN 3'h6
`define VPCE_PORT_C 4'h2
`define VPCE_ROUTE_OFF 2'h0
`define VPCE_RATE_1X 2'h0
`define VPCE_RATE_2X 2'h1
`define VPCE_RATE_4X 2'h2
`define VPCE_SNS_BOTH 3'h0
`define VPCE_SNS_RISE 3'h1
`define VPCE_SNS_FALL 3'h2
`define VPCE_SNS_LOW 3'h3
`define VPCE_SNS_OFF 3'h7
`define VPCE_RESP_OKAY 2'h0
`define VPCE_RESP_SLVERR 2'h2

`endif

// ==== design/vpce_pkg.sv ====
// Types shared by the virtual port block
package vpce_pkg;

	typedef struct packed {
		logic pin_choice;
		logic rtc_en;
		logic [1:0] ev_port;
		logic [1:0] rate;
		logic [1:0] clk_port;
	} vpce_clkev_s;

	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} vpce_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} vpce_axi_rsp_s;

	typedef enum logic [1:0] {RG_NONE, RG_CFG, RG_PORT} vpce_region_e;

	typedef struct packed {
		vpce_region_e region;
		logic [5:0] sel;
		logic [3:0] port;
	} vpce_dec_s;

	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] prev;
		logic [7:0] lvl;
		logic [1:0] hit;
	} vpce_sense_s;

endpackage

// ==== design/vpce_sense.sv ====
// Pin synchroniser, input gating and sense detection of one port
`timescale 1ns/1ps
`include "vpce_map.svh"
module vpce_sense import vpce_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Pins and configuration
	input wire logic [7:0] pin_in,
	input wire logic [23:0] sense,
	input wire logic [7:0] mask0,
	input wire logic [7:0] mask1,
	// Results
	output logic [7:0] lvl,
	output logic [1:0] hit
);
	vpce_sense_s st;
	vpce_sense_s nx;

	always_comb begin
		logic [2:0] cfg;
		logic [7:0] m;
		cfg = 3'h0;
		m = 8'h00;
		nx = st;
		nx.s1 = pin_in;
		nx.s2 = st.s1;
		nx.prev = st.s2;
		for (int i = 0; i < 8; i++) begin
			cfg = sense[i*3 +: 3];
			case (cfg)
			`VPCE_SNS_BOTH: m[i] = st.s2[i] ^ st.prev[i];
			`VPCE_SNS_RISE: m[i] = st.s2[i] & ~st.prev[i];
			`VPCE_SNS_FALL: m[i] = ~st.s2[i] & st.prev[i];
			`VPCE_SNS_LOW: m[i] = ~st.s2[i];
			default: m[i] = 1'b0;
			endcase
			nx.lvl[i] = (cfg == `VPCE_SNS_OFF) ? 1'b0 : st.s2[i];
		end
		nx.hit[0] = |(m & mask0);
		nx.hit[1] = |(m & mask1);
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign lvl = st.lvl;
	assign hit = st.hit;
endmodule

// ==== design/vpce_top.sv ====
// Virtual port windows, port banks and clock/event pin routing
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "vpce_map.svh"
module vpce_top import vpce_pkg::*; #(
	parameter int NUM_PORTS = 6
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Register bus
	input wire vpce_axi_req_s axi_req,
	output vpce_axi_rsp_s axi_rsp,
	// Pins
	input wire logic [NUM_PORTS-1:0][7:0] pin_in,
	output logic [NUM_PORTS-1:0][7:0] pin_out,
	output logic [NUM_PORTS-1:0][7:0] pin_oe,
	// Clock and event sources
	input wire logic rtc_clk,
	input wire logic [7:0] ev_chan,
	// Interrupt
	output logic irq
);
	localparam int NP = NUM_PORTS;

	typedef struct packed {
		logic aw_rdy;
		logic w_rdy;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] maps;
		vpce_clkev_s clkev;
		logic [2:0] evsel;
		logic [NP-1:0][7:0] dir;
		logic [NP-1:0][7:0] out;
		logic [NP-1:0][1:0] flags;
		logic [NP-1:0][7:0] mask0;
		logic [NP-1:0][7:0] mask1;
		logic [NP-1:0][23:0] sense;
		logic [NP-1:0] stat;
		logic [NP-1:0] en;
		logic irq;
		logic [2:0] div;
		logic rtc_s1;
		logic rtc_s2;
		logic [NP-1:0][7:0] pin_out;
		logic [NP-1:0][7:0] pin_oe;
	} vpce_state_s;

	vpce_state_s st;
	vpce_state_s nx;
	logic [NP-1:0][7:0] lvl_w;
	logic [NP-1:0][1:0] hit_w;
	vpce_dec_s rdec;
	vpce_dec_s wdec;
	logic do_wr;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic vpce_dec_s decode(input logic [11:0] a,
			input logic [15:0] maps);
		vpce_dec_s d;
		logic [11:0] off;
		d = '0;
		off = a - `VPCE_PP_BASE;
		d.region = RG_NONE;
		if (a[1:0] != 2'h0) begin
			d.region = RG_NONE;
		end else if (a < `VPCE_VP_BASE) begin
			d.region = RG_CFG;
			d.sel = a[7:2];
		end else if (a < `VPCE_VP_END) begin
			d.region = RG_PORT;
			d.sel = {4'h0, a[3:2]};
			d.port = maps[{a[5:4], 2'b00} +: 4];
		end else if (a >= `VPCE_PP_BASE && a < `VPCE_PP_END) begin
			d.region = (a[4:2] > `VPCE_P_SENSE) ? RG_NONE : RG_PORT;
			d.sel = {3'h0, a[4:2]};
			d.port = off[8:5];
		end
		return d;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] ws);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (ws[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Port sense units
	// ----------------------------------------
	for (genvar p = 0; p < NP; p++) begin : g_port
		vpce_sense u_sense (
			.mclk(mclk),
			.nrst(nrst),
			.pin_in(pin_in[p]),
			.sense(st.sense[p]),
			.mask0(st.mask0[p]),
			.mask1(st.mask1[p]),
			.lvl(lvl_w[p]),
			.hit(hit_w[p])
		);
	end

	assign rdec = decode(axi_req.araddr, st.maps);
	assign wdec = decode(st.awaddr, st.maps);
	assign do_wr = !st.aw_rdy && !st.w_rdy && !st.bvalid;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [31:0] rd;
		logic ok;
		logic [NP-1:0][1:0] clr;
		logic [NP-1:0] sclr;
		logic [2:0] pin;
		logic wave;
		logic evl;
		rd = 32'h0000_0000;
		ok = 1'b1;
		clr = '0;
		sclr = '0;
		pin = `VPCE_PIN_DEF;
		wave = 1'b0;
		evl = 1'b0;
		nx = st;

		// Write channels
		if (axi_req.awvalid && st.aw_rdy) begin
			nx.aw_rdy = 1'b0;
			nx.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st.w_rdy) begin
			nx.w_rdy = 1'b0;
			nx.wdata = axi_req.wdata;
			nx.wstrb = axi_req.wstrb;
		end
		if (st.bvalid && axi_req.bready) begin
			nx.bvalid = 1'b0;
			nx.aw_rdy = 1'b1;
			nx.w_rdy = 1'b1;
		end
		if (do_wr) begin
			nx.bvalid = 1'b1;
			nx.bresp = `VPCE_RESP_OKAY;
			case (wdec.region)
			RG_CFG: begin
				case (wdec.sel)
				`VPCE_CTRLA_IDX: nx.maps[7:0] =
					8'(merge({24'h0, st.maps[7:0]}, st.wdata, st.wstrb));
				`VPCE_CTRLB_IDX: nx.maps[15:8] =
					8'(merge({24'h0, st.maps[15:8]}, st.wdata, st.wstrb));
				`VPCE_CLKEV_IDX: nx.clkev =
					8'(merge({24'h0, st.clkev}, st.wdata, st.wstrb));
				`VPCE_EVCTL_IDX: nx.evsel =
					3'(merge({29'h0, st.evsel}, st.wdata, st.wstrb));
				`VPCE_IRQ_CLR_IDX: sclr =
					NP'(merge(32'h0, st.wdata, st.wstrb));
				`VPCE_IRQ_EN_IDX: nx.en =
					NP'(merge(32'(st.en), st.wdata, st.wstrb));
				`VPCE_IRQ_STAT_IDX: ok = 1'b1;
				default: ok = 1'b0;
				endcase
			end
			RG_PORT: begin
				for (int p = 0; p < NP; p++) begin
					// Ports beyond NP never match here
					if (32'(wdec.port) == p) begin
						case (wdec.sel[2:0])
						`VPCE_P_DIR: nx.dir[p] =
							8'(merge({24'h0, st.dir[p]}, st.wdata, st.wstrb));
						`VPCE_P_OUT: nx.out[p] =
							8'(merge({24'h0, st.out[p]}, st.wdata, st.wstrb));
						`VPCE_P_FLAGS: clr[p] =
							2'(merge(32'h0, st.wdata, st.wstrb));
						`VPCE_P_MASK0: nx.mask0[p] =
							8'(merge({24'h0, st.mask0[p]}, st.wdata, st.wstrb));
						`VPCE_P_MASK1: nx.mask1[p] =
							8'(merge({24'h0, st.mask1[p]}, st.wdata, st.wstrb));
						`VPCE_P_SENSE: nx.sense[p] =
							24'(merge({8'h0, st.sense[p]}, st.wdata, st.wstrb));
						default: nx.sense[p] = st.sense[p];
						endcase
					end
				end
			end
			default: ok = 1'b0;
			endcase
			nx.bresp = ok ? `VPCE_RESP_OKAY : `VPCE_RESP_SLVERR;
		end

		// Read channel
		if (st.rvalid && axi_req.rready) begin
			nx.rvalid = 1'b0;
			nx.ar_rdy = 1'b1;
		end
		if (axi_req.arvalid && st.ar_rdy) begin
			ok = 1'b1;
			case (rdec.region)
			RG_CFG: begin
				case (rdec.sel)
				`VPCE_CTRLA_IDX: rd = {24'h0, st.maps[7:0]};
				`VPCE_CTRLB_IDX: rd = {24'h0, st.maps[15:8]};
				`VPCE_CLKEV_IDX: rd = {24'h0, st.clkev};
				`VPCE_EVCTL_IDX: rd = {29'h0, st.evsel};
				`VPCE_IRQ_STAT_IDX: rd = 32'(st.stat);
				`VPCE_IRQ_EN_IDX: rd = 32'(st.en);
				`VPCE_IRQ_CLR_IDX: rd = 32'h0000_0000;
				default: ok = 1'b0;
				endcase
			end
			RG_PORT: begin
				for (int p = 0; p < NP; p++) begin
					if (32'(rdec.port) == p) begin
						case (rdec.sel[2:0])
						`VPCE_P_DIR: rd = {24'h0, st.dir[p]};
						`VPCE_P_OUT: rd = {24'h0, st.out[p]};
						`VPCE_P_IN: rd = {24'h0, lvl_w[p]};
						`VPCE_P_FLAGS: rd = {30'h0, st.flags[p]};
						`VPCE_P_MASK0: rd = {24'h0, st.mask0[p]};
						`VPCE_P_MASK1: rd = {24'h0, st.mask1[p]};
						`VPCE_P_SENSE: rd = {8'h0, st.sense[p]};
						default: rd = 32'h0000_0000;
						endcase
					end
				end
			end
			default: ok = 1'b0;
			endcase
			nx.ar_rdy = 1'b0;
			nx.rvalid = 1'b1;
			nx.rdata = rd;
			nx.rresp = ok ? `VPCE_RESP_OKAY : `VPCE_RESP_SLVERR;
		end

		// Flags, set wins over clear
		for (int p = 0; p < NP; p++) begin
			nx.flags[p] = (st.flags[p] & ~clr[p]) | hit_w[p];
		end
		nx.stat = st.stat & ~sclr;
		for (int p = 0; p < NP; p++) begin
			if (hit_w[p] != 2'h0) begin
				nx.stat[p] = 1'b1;
			end
		end
		nx.irq = |(st.stat & st.en);

		// Clock and event pin routing
		nx.div = st.div + 3'h1;
		nx.rtc_s1 = rtc_clk;
		nx.rtc_s2 = st.rtc_s1;
		pin = st.clkev.pin_choice ? `VPCE_PIN_ALT : `VPCE_PIN_DEF;
		case (st.clkev.rate)
		`VPCE_RATE_1X: wave = st.div[2];
		`VPCE_RATE_2X: wave = st.div[1];
		`VPCE_RATE_4X: wave = st.div[0];
		default: wave = 1'b0;
		endcase
		evl = ev_chan[st.evsel];
		for (int p = 0; p < NP; p++) begin
			nx.pin_out[p] = st.out[p];
			nx.pin_oe[p] = st.dir[p];
			if (st.clkev.ev_port != `VPCE_ROUTE_OFF &&
					32'(st.clkev.ev_port) + 1 == p && st.dir[p][pin]) begin
				nx.pin_out[p][pin] = evl;
			end
			if (st.clkev.clk_port != `VPCE_ROUTE_OFF &&
					32'(st.clkev.clk_port) + 1 == p && st.dir[p][pin]) begin
				nx.pin_out[p][pin] = wave;
			end
			if (st.clkev.rtc_en && p == 32'(`VPCE_PORT_C)) begin
				nx.pin_out[p][`VPCE_RTC_PIN] = st.rtc_s2;
				nx.pin_oe[p][`VPCE_RTC_PIN] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st <= '0;
			st.aw_rdy <= 1'b1;
			st.w_rdy <= 1'b1;
			st.ar_rdy <= 1'b1;
			st.clkev <= `VPCE_CLKEV_RST;
		end else begin
			st <= nx;
		end
	end

	assign axi_rsp.awready = st.aw_rdy;
	assign axi_rsp.wready = st.w_rdy;
	assign axi_rsp.bvalid = st.bvalid;
	assign axi_rsp.bresp = st.bresp;
	assign axi_rsp.arready = st.ar_rdy;
	assign axi_rsp.rvalid = st.rvalid;
	assign axi_rsp.rdata = st.rdata;
	assign axi_rsp.rresp = st.rresp;
	assign pin_out = st.pin_out;
	assign pin_oe = st.pin_oe;
	assign irq = st.irq;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_clkev_reset;
		@(posedge mclk) !nrst |=> st.clkev == `VPCE_CLKEV_RST;
	endproperty
	a_clkev_reset: assert property (p_clkev_reset) else $error("ctl not reset");

	property p_flag_set;
		@(posedge mclk) disable iff (!nrst) hit_w[3][0] |=> st.flags[3][0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag lost");

	property p_flag_clr;
		@(posedge mclk) disable iff (!nrst)
		do_wr && wdec.region == RG_PORT && wdec.port == 4'h3 &&
		wdec.sel == 6'(`VPCE_P_FLAGS) && st.wstrb[0] && st.wdata[0] &&
		!hit_w[3][0] |=> !st.flags[3][0];
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag kept");

	property p_win0_dir;
		@(posedge mclk) disable iff (!nrst)
		axi_req.arvalid && st.ar_rdy && axi_req.araddr == `VPCE_VP_BASE &&
		st.maps[3:0] == 4'h0 |=> st.rdata[7:0] == $past(st.dir[0]);
	endproperty
	a_win0_dir: assert property (p_win0_dir) else $error("window read bad");

	property p_unimpl;
		@(posedge mclk) disable iff (!nrst)
		axi_req.arvalid && st.ar_rdy && rdec.region == RG_PORT &&
		32'(rdec.port) >= NP |=> st.rdata == 32'h0000_0000;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("ghost port data");

	property p_clk_prio;
		@(posedge mclk) disable iff (!nrst)
		st.clkev.clk_port == 2'h1 && st.clkev.ev_port == 2'h1 &&
		st.clkev.rate == `VPCE_RATE_4X && !st.clkev.pin_choice && st.dir[2][7]
		|=> st.pin_out[2][7] == $past(st.div[0]);
	endproperty
	a_clk_prio: assert property (p_clk_prio) else $error("clock lost");

	property p_ev_nodir;
		@(posedge mclk) disable iff (!nrst)
		st.clkev.ev_port == 2'h1 && st.clkev.clk_port != 2'h1 &&
		!st.clkev.pin_choice && !st.dir[2][7]
		|=> st.pin_out[2][7] == $past(st.out[2][7]);
	endproperty
	a_ev_nodir: assert property (p_ev_nodir) else $error("event on input");

	property p_ev_route;
		@(posedge mclk) disable iff (!nrst)
		st.clkev.ev_port == 2'h2 && st.clkev.clk_port != 2'h2 &&
		st.clkev.pin_choice && st.dir[3][4]
		|=> st.pin_out[3][4] == $past(ev_chan[st.evsel]);
	endproperty
	a_ev_route: assert property (p_ev_route) else $error("event missing");

	property p_rtc;
		@(posedge mclk) disable iff (!nrst)
		st.clkev.rtc_en |=> st.pin_oe[2][6] && st.pin_out[2][6] == $past(st.rtc_s2);
	endproperty
	a_rtc: assert property (p_rtc) else $error("rtc clock missing");

	property p_irq;
		@(posedge mclk) disable iff (!nrst)
		1'b1 |=> st.irq == $past(|(st.stat & st.en));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_rd_answer;
		@(posedge mclk) disable iff (!nrst)
		axi_req.arvalid && st.ar_rdy |=> st.rvalid && !st.ar_rdy;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

	c_write: cover property (@(posedge mclk) do_wr);
	c_read: cover property (@(posedge mclk) st.rvalid && axi_req.rready);
	c_flag: cover property (@(posedge mclk) st.flags[3] != 2'h0);
	c_irq: cover property (@(posedge mclk) st.irq);
endmodule

// ==== verif/vpce_top_bench.sv ====
// Self-checking bench of the virtual port block
`timescale 1ns/1ps
module vpce_top_bench import vpce_pkg::*;;

	typedef struct packed {
		logic [1:0] resp;
		logic [31:0] mask;
		logic [31:0] data;
	} vpce_rexp_s;

	logic mclk = 1'b0;
	logic nrst = 1'b0;
	vpce_axi_req_s req = '{bready: 1'b1, rready: 1'b1, default: '0};
	vpce_axi_rsp_s rsp;
	logic [5:0][7:0] pin_in = '0;
	logic [5:0][7:0] pin_out;
	logic [5:0][7:0] pin_oe;
	logic rtc_clk = 1'b0;
	logic [7:0] ev_chan = 8'h00;
	logic irq;
	int n_mismatch = 0;
	int num_checks = 0;
	int seed = 32'h5D0C96E0;
	logic [1:0] bq[$];
	vpce_rexp_s rq[$];
	vpce_rexp_s re;

	always #2 mclk = ~mclk;

	vpce_top #(.NUM_PORTS(6)) i_vpce_top (
		.mclk(mclk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.rtc_clk(rtc_clk), .ev_chan(ev_chan), .irq(irq)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (!ok) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	function automatic logic [11:0] pa(input int p, input int r);
		return 12'(12'h100 + p * 32 + r);
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r = 2'h0);
		int t;
		bq.push_back(r);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		t = 0;
		do begin
			@(posedge mclk);
			t++;
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid && t < 100);
		if (t >= 100) chk(1'b0, "write hang");
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'hFF, input logic [1:0] r = 2'h0);
		int t;
		rq.push_back('{resp: r, mask: m, data: d});
		req.arvalid <= 1'b1;
		req.araddr <= a;
		t = 0;
		do begin
			@(posedge mclk);
			t++;
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid && t < 100);
		if (t >= 100) chk(1'b0, "read hang");
	endtask

	task automatic togg(input int p, input int b, input int exp);
		int n;
		logic last;
		n = 0;
		@(posedge mclk);
		last = pin_out[p][b];
		repeat (16) begin
			@(posedge mclk);
			if (pin_out[p][b] !== last) n++;
			last = pin_out[p][b];
		end
		chk(n == exp, $sformatf("pin %0d.%0d toggles %0d", p, b, n));
	endtask

	// ----------------------------------------
	// Response monitor
	// ----------------------------------------
	always @(posedge mclk) begin
		if (rsp.bvalid && req.bready) begin
			if (bq.size() == 0) chk(1'b0, "stray write response");
			else chk(rsp.bresp === bq.pop_front(), "write response");
		end
		if (rsp.rvalid && req.rready) begin
			if (rq.size() == 0) begin
				chk(1'b0, "stray read response");
			end else begin
				re = rq.pop_front();
				chk(rsp.rresp === re.resp && (rsp.rdata & re.mask) === re.data,
					$sformatf("read data %h resp %h", rsp.rdata, rsp.rresp));
			end
		end
	end

	initial begin
		repeat (50000) @(posedge mclk);
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		conclude();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		int k;
		int p;
		int c;
		logic [7:0] d;
		logic [7:0] o;
		logic e;
		logic [4:0] ef;
		logic [4:0] er;
		ef = 5'b01101;
		er = 5'b01011;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		chk(pin_out === '0 && pin_oe === '0 && irq === 1'b0, "reset pins");
		rd(12'h010, 32'h0, 32'hFFFFFFFF);
		d = 8'($random(seed));
		wr(12'h010, 32'(d));
		rd(12'h010, 32'(d));
		wr(12'h010, 32'h0);
		rd(12'h014, 32'h0, 32'h0, 2'h2);
		rd(12'h011, 32'h0, 32'h0, 2'h2);
		wr(12'h014, 32'hFF, 2'h2);
		$display("test reset_regs done");

		for (k = 0; k < 7; k++) begin
			p = (k == 6) ? 15 : k;
			wr(12'h00C, 32'(p));
			d = 8'($random(seed));
			o = 8'($random(seed));
			wr(12'h060, 32'(d));
			wr(12'h064, 32'(o));
			if (p < 6) begin
				rd(pa(p, 0), 32'(d));
				if (p == 0) rd(12'h040, 32'(d));
				rd(pa(p, 4), 32'(o));
				cyc(2);
				chk(pin_oe[p] === d && pin_out[p] === o, "pin drive");
				pin_in[p] <= 8'($random(seed));
				cyc(5);
				rd(12'h068, 32'(pin_in[p]));
				wr(pa(p, 'h18), 32'h7);
				cyc(5);
				rd(12'h068, 32'(pin_in[p] & 8'hFE));
				wr(pa(p, 'h18), 32'h0);
			end else begin
				rd(12'h060, 32'h0);
				rd(12'h064, 32'h0);
			end
		end
		$display("test windows done");

		wr(12'h00C, 32'h3);
		wr(pa(3, 'h10), 32'h1);
		wr(pa(3, 'h14), 32'h1);
		for (k = 0; k < 10; k++) begin
			pin_in[3] <= {7'h0, k[0]};
			wr(pa(3, 'h18), 32'(k / 2));
			cyc(6);
			wr(12'h06C, 32'h3);
			cyc(2);
			pin_in[3] <= {7'h0, ~k[0]};
			cyc(6);
			e = k[0] ? ef[k / 2] : er[k / 2];
			rd(12'h06C, {30'h0, e, e});
			wr(12'h06C, 32'h0);
			rd(12'h06C, {30'h0, e, e});
		end
		wr(pa(3, 'h18), 32'h1);
		wr(12'h06C, 32'h3);
		wr(12'h024, 32'h8);
		rd(12'h020, 32'h0);
		pin_in[3] <= 8'h01;
		cyc(8);
		chk(irq === 1'b0, "irq while masked");
		rd(12'h020, 32'h8);
		wr(12'h020, 32'h0);
		rd(12'h020, 32'h8);
		wr(12'h028, 32'h8);
		rd(12'h028, 32'h8);
		cyc(3);
		chk(irq === 1'b1, "irq enabled");
		wr(12'h06C, 32'h3);
		wr(12'h024, 32'h8);
		cyc(3);
		chk(irq === 1'b0, "irq cleared");
		$display("test flags_irq done");

		for (p = 2; p < 5; p++) begin
			wr(pa(p, 0), 32'h90);
			wr(pa(p, 4), 32'h0);
		end
		for (k = 0; k < 24; k++) begin
			c = k % 3 + 1;
			wr(12'h018, 32'(k / 3));
			wr(12'h010, 32'(((k % 2) << 7) | (c << 4)));
			ev_chan <= 8'($random(seed));
			cyc(3);
			e = pin_out[c + 1][(k % 2) ? 4 : 7];
			chk(e === ev_chan[k / 3], "event pin");
		end
		ev_chan <= 8'hFF;
		wr(12'h010, 32'h0);
		cyc(3);
		chk(pin_out[2][7] === 1'b0, "event off");
		wr(12'h010, 32'h10);
		wr(pa(2, 0), 32'h0);
		cyc(3);
		e = pin_out[2][7] | pin_oe[2][7];
		chk(e === 1'b0, "event no dir");
		wr(pa(2, 0), 32'h90);
		$display("test event_route done");

		ev_chan <= 8'h00;
		for (k = 0; k < 12; k++) begin
			c = k % 3 + 1;
			wr(12'h010, 32'(((k / 3) << 2) | (c << 4) | c));
			p = (k < 3) ? 4 : (k < 6) ? 8 : (k < 9) ? 16 : 0;
			togg(c + 1, 7, p);
		end
		wr(12'h010, 32'h08);
		togg(2, 7, 0);
		wr(12'h010, 32'h89);
		togg(2, 4, 16);
		wr(pa(2, 0), 32'h0);
		togg(2, 4, 0);
		$display("test clock_route done");

		wr(12'h010, 32'h40);
		for (k = 0; k < 4; k++) begin
			rtc_clk <= ~k[0];
			cyc(6);
			e = pin_out[2][6] === rtc_clk;
			chk(e && pin_oe[2][6] === 1'b1, "rtc pin");
		end
		wr(12'h010, 32'h0);
		cyc(3);
		chk(pin_oe[2][6] === 1'b0, "rtc off");
		$display("test rtc_out done");
		conclude();
	end

endmodule
